// File: drpor_defines.vh
// Constants for the dual rail power-on reset sequencer.
`ifndef DRPOR_DEFINES_VH
`define DRPOR_DEFINES_VH
`define DRPOR_CLK_HZ        125000000
`define DRPOR_SLOW_HZ       22500
`define DRPOR_HOLD_MS       180
// Clocks per slow tick and ticks per hold, rounded up and sized to the counters.
`define DRPOR_SLOW_DIV      13'h15B4
`define DRPOR_HOLD_TICKS    13'hFD2
`define DRPOR_DIV_W         13
`define DRPOR_HOLD_W        13
`define DRPOR_ST_RESET      2'h0
`define DRPOR_ST_HOLD       2'h1
`define DRPOR_ST_RUN        2'h2
`define DRPOR_TREE_W        8
// Clocks from a pin change to its settled level: three flops plus the agree stage.
`define DRPOR_SENSE_LAG     4
`endif

// File: drpor_sequencer.v
// Dual rail power-on reset sequencer with strap-selected tree test mode.
`timescale 1ns/10ps
`include "drpor_defines.vh"

module drpor_sequencer
#(
  parameter [`DRPOR_DIV_W-1:0]  SLOW_DIV   = `DRPOR_SLOW_DIV,
  parameter [`DRPOR_HOLD_W-1:0] HOLD_TICKS = `DRPOR_HOLD_TICKS
)
(
  input  wire                     clock_i,
  input  wire                     reset_n_i,
  input  wire                     standby_supply_ok_i,
  input  wire                     main_supply_ok_i,
  input  wire                     main_rail_reset_n_i,
  output wire                     main_rail_reset_n_o,
  output wire                     main_rail_reset_n_oe_o,
  output wire                     standby_rail_reset_n_o,
  input  wire                     diode_cathode_pin_i,
  input  wire [`DRPOR_TREE_W-1:0] tree_inputs_i,
  output reg                      tree_test_mode_o,
  output reg                      tree_test_result_out_o,
  output wire                     tree_test_result_oe_o,
  output wire                     external_reset_o
);

  // Three-stage synchronisers for the supply, reset pin and strap inputs; the tree inputs are not synchronised.
  reg [2:0] stby_sync_reg;
  reg [2:0] main_sync_reg;
  reg [2:0] ext_sync_reg;
  reg [2:0] strap_sync_reg;
  reg       stby_ok_reg;
  reg       main_ok_reg;
  reg       ext_low_reg;
  reg       strap_reg;
  reg       strap_taken_reg;
  reg [`DRPOR_DIV_W-1:0]  div_reg;
  reg                     tick_reg;
  reg [1:0]               stby_state_reg;
  reg [`DRPOR_HOLD_W-1:0] stby_cnt_reg;
  reg [1:0]               main_state_reg;
  reg [`DRPOR_HOLD_W-1:0] main_cnt_reg;
  reg                     main_drive_reg;
  wire                    stby_released;
  wire                    main_ready;
  reg                     stby_out_reg;
  reg [`DRPOR_SENSE_LAG-1:0] drive_hist_reg;

  // Sequencer state codes, shared by both rails.
  localparam [1:0] ST_RESET = `DRPOR_ST_RESET;
  localparam [1:0] ST_HOLD  = `DRPOR_ST_HOLD;
  localparam [1:0] ST_RUN   = `DRPOR_ST_RUN;

  // A synchroniser has settled once its second and third stages agree.
  function sync_agree;
    input [2:0] stages;
    begin
      sync_agree = (stages[1] == stages[2]);
    end
  endfunction

  // True on the count that the last slow tick of a hold interval ends.
  function hold_last;
    input [`DRPOR_HOLD_W-1:0] count;
    begin
      hold_last = (count == HOLD_TICKS - 1'b1);
    end
  endfunction

  // A level counts only once the second and third stages agree.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stby_sync_reg  <= 3'h0;
      main_sync_reg  <= 3'h0;
      ext_sync_reg   <= 3'h7;
      strap_sync_reg <= 3'h0;
      stby_ok_reg    <= 1'b0;
      main_ok_reg    <= 1'b0;
      ext_low_reg    <= 1'b0;
      strap_reg      <= 1'b0;
    end
    else
    begin
      stby_sync_reg  <= {stby_sync_reg[1:0], standby_supply_ok_i};
      main_sync_reg  <= {main_sync_reg[1:0], main_supply_ok_i};
      ext_sync_reg   <= {ext_sync_reg[1:0], main_rail_reset_n_i};
      strap_sync_reg <= {strap_sync_reg[1:0], diode_cathode_pin_i};
      if (sync_agree(stby_sync_reg))
        stby_ok_reg <= stby_sync_reg[2];
      if (sync_agree(main_sync_reg))
        main_ok_reg <= main_sync_reg[2];
      if (sync_agree(ext_sync_reg))
        ext_low_reg <= ~ext_sync_reg[2];
      if (sync_agree(strap_sync_reg))
        strap_reg <= strap_sync_reg[2];
    end
  end

  // Slow oscillator stand-in: one-cycle tick every SLOW_DIV clocks.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_reg  <= {`DRPOR_DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end
    else if (div_reg == SLOW_DIV - 1'b1)
    begin
      div_reg  <= {`DRPOR_DIV_W{1'b0}};
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Standby sequencer; a dip drops back to reset and the count restarts.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stby_state_reg <= ST_RESET;
      stby_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
    end
    else if (!stby_ok_reg)
    begin
      stby_state_reg <= ST_RESET;
      stby_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
    end
    else
    begin
      case (stby_state_reg)
        ST_RESET:
        begin
          stby_state_reg <= ST_HOLD;
          stby_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
        end
        ST_HOLD:
        begin
          if (tick_reg)
          begin
            if (hold_last(stby_cnt_reg))
              stby_state_reg <= ST_RUN;
            stby_cnt_reg <= stby_cnt_reg + 1'b1;
          end
        end
        ST_RUN:
          stby_state_reg <= ST_RUN;
        default:
          stby_state_reg <= ST_RESET;
      endcase
    end
  end

  assign stby_released = (stby_state_reg == ST_RUN);

  // Main hold starts only once main is good and standby has released,
  // so a late standby pushes the main release out by a full hold.
  // The external request is not fed back into main's own hold, which
  // would otherwise latch the pin low forever through our own drive.
  assign main_ready = main_ok_reg & stby_released;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      main_state_reg <= ST_RESET;
      main_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
    end
    else if (!main_ready)
    begin
      main_state_reg <= ST_RESET;
      main_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
    end
    else
    begin
      case (main_state_reg)
        ST_RESET:
        begin
          main_state_reg <= ST_HOLD;
          main_cnt_reg   <= {`DRPOR_HOLD_W{1'b0}};
        end
        ST_HOLD:
        begin
          if (tick_reg)
          begin
            if (hold_last(main_cnt_reg))
              main_state_reg <= ST_RUN;
            main_cnt_reg <= main_cnt_reg + 1'b1;
          end
        end
        ST_RUN:
          main_state_reg <= ST_RUN;
        default:
          main_state_reg <= ST_RESET;
      endcase
    end
  end

  // Registered reset drives, so no decode glitch reaches a reset pin.
  // A supply drop forces the reset on the same clock that the state drops back to reset.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      main_drive_reg <= 1'b1;
      stby_out_reg   <= 1'b0;
      drive_hist_reg <= {`DRPOR_SENSE_LAG{1'b1}};
    end
    else
    begin
      main_drive_reg <= ~main_ready | (main_state_reg != ST_RUN);
      stby_out_reg   <= stby_ok_reg & (stby_state_reg == ST_RUN);
      drive_hist_reg <= {drive_hist_reg[`DRPOR_SENSE_LAG-2:0], main_drive_reg};
    end
  end

  assign standby_rail_reset_n_o = stby_out_reg;
  assign main_rail_reset_n_o    = 1'b0;
  assign main_rail_reset_n_oe_o = main_drive_reg;
  // Our own pull-low needs the synchroniser's lag to drain after we release,
  // so the sensed pin is ignored that long to avoid a false external reset.
  assign external_reset_o = ext_low_reg & ~main_drive_reg & ~(|drive_hist_reg);

  // Strap is caught once, on the first settled sample after standby comes up.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_taken_reg  <= 1'b0;
      tree_test_mode_o <= 1'b0;
    end
    else if (!stby_ok_reg)
    begin
      strap_taken_reg  <= 1'b0;
      tree_test_mode_o <= 1'b0;
    end
    else if (!strap_taken_reg && sync_agree(stby_sync_reg))
    begin
      strap_taken_reg  <= 1'b1;
      tree_test_mode_o <= strap_reg;
    end
  end

  // NAND tree chain result, registered onto the address strap pin.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tree_test_result_out_o <= 1'b0;
    else
      tree_test_result_out_o <= ~(&tree_inputs_i);
  end

  assign tree_test_result_oe_o = tree_test_mode_o;

endmodule // drpor_sequencer

// File: drpor_chk_sva.sv
// Port checker for the dual rail power-on reset sequencer.
`timescale 1ns/10ps
module drpor_chk_sva
#(
  parameter int SLOW_DIV   = 4,
  parameter int HOLD_TICKS = 5
)
(
  input wire       clock_i,
  input wire       reset_n_i,
  input wire       standby_supply_ok_i,
  input wire       main_supply_ok_i,
  input wire       main_rail_reset_n_i,
  input wire       main_rail_reset_n_o,
  input wire       main_rail_reset_n_oe_o,
  input wire       standby_rail_reset_n_o,
  input wire [7:0] tree_inputs_i,
  input wire       tree_test_mode_o,
  input wire       tree_test_result_out_o,
  input wire       external_reset_o
);
  localparam int LO = (HOLD_TICKS - 1) * SLOW_DIV;
  localparam int HI = (HOLD_TICKS + 2) * SLOW_DIV + 8;
  logic [7:0] s_reg, m_reg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Unbroken good cycles; a dip zeroes them, so a hold that fails to restart is caught.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_reg <= 8'h00;
      m_reg <= 8'h00;
    end
    else
    begin
      s_reg <= standby_supply_ok_i ? s_reg + {7'h00, ~&s_reg} : 8'h00;
      m_reg <= (main_supply_ok_i && standby_rail_reset_n_o) ? m_reg + {7'h00, ~&m_reg} : 8'h00;
    end
  end
  a_stby_follow: assert property (!standby_supply_ok_i [*7] |-> !standby_rail_reset_n_o) else $error("stby");
  a_stby_early: assert property ($rose(standby_rail_reset_n_o) |-> s_reg >= LO) else $error("stby early");
  a_stby_late: assert property (s_reg == HI |-> standby_rail_reset_n_o) else $error("stby late");
  a_main_follow: assert property (!main_supply_ok_i [*8] |-> main_rail_reset_n_oe_o) else $error("main");
  a_main_early: assert property ($fell(main_rail_reset_n_oe_o) |-> m_reg >= LO) else $error("early");
  a_main_late: assert property (m_reg == HI |-> !main_rail_reset_n_oe_o) else $error("main late");
  a_pin_sense: assert property ((!main_rail_reset_n_i && !main_rail_reset_n_oe_o) [*5] |->
    external_reset_o && !main_rail_reset_n_o) else $error("sense");
  // Our own release must not echo back as an outside reset while the synchroniser drains.
  a_pin_quiet: assert property ($fell(main_rail_reset_n_oe_o) && main_rail_reset_n_i |->
    (!external_reset_o) [*4]) else $error("false external reset");
  a_tree_nand: assert property (tree_test_mode_o && $past(tree_test_mode_o) |->
    tree_test_result_out_o == ~&$past(tree_inputs_i)) else $error("tree");
  c_stby: cover property ($rose(standby_rail_reset_n_o));
  c_main: cover property ($fell(main_rail_reset_n_oe_o));
  c_ext: cover property ($rose(external_reset_o));
  c_tree: cover property (tree_test_mode_o && !tree_test_result_out_o);
endmodule // drpor_chk_sva

// File: drpor_board.sv
// Board model of the reset pins: pull-up, outside reset switch and test strap.
`timescale 1ns/10ps
module drpor_board
(
  input  wire pull_low_i,
  input  wire strap_high_i,
  input  wire dev_oe_i,
  output wire pin_level_o,
  output wire strap_o
);
  // The pull-up keeps the line high unless someone sinks it.
  assign pin_level_o = !(pull_low_i || dev_oe_i);
  // A fitted strap is steady from before power-up.
  assign strap_o = strap_high_i;
endmodule // drpor_board

// File: tb_top.sv
// Self-checking bench for the dual rail power-on reset sequencer.
`timescale 1ns/10ps
module tb_top;
  logic clock_i = 1'h0, reset_n_i = 1'h0, standby_supply_ok_i = 1'h0, main_supply_ok_i = 1'h0;
  logic pull = 1'h0, strap = 1'h0, pm = 1'h0, main_rail_reset_n_i, main_rail_reset_n_oe_o, diode_cathode_pin_i;
  logic standby_rail_reset_n_o, tree_test_mode_o, tree_test_result_out_o, tree_test_result_oe_o, external_reset_o;
  logic [7:0] tree_inputs_i = 8'h00, tp = 8'h00;
  logic [1:0] cur, last = 2'h0;
  logic [15:0] pv = 16'h0000;
  logic [31:0] seed = 32'h7563D4A6;
  logic q[2][$];
  int fails = 0, checks = 0, cycles = 0;
  // Steps: standby, main, pull, strap, expected standby reset, expected pin, then cycles in the low byte.
  logic [15:0] tbl[11] = '{16'hCC50, 16'h880C, 16'hCC3C, 16'hE80A, 16'hCC0A, 16'h400C, 16'hC00C, 16'h400C,
                           16'hCC50, 16'h100C, 16'hDC64};
  drpor_sequencer #(.SLOW_DIV(13'h4), .HOLD_TICKS(13'h5)) i_dut (.clock_i, .reset_n_i, .standby_supply_ok_i,
    .main_supply_ok_i, .main_rail_reset_n_i, .main_rail_reset_n_o(), .main_rail_reset_n_oe_o,
    .standby_rail_reset_n_o, .diode_cathode_pin_i, .tree_inputs_i, .tree_test_mode_o, .tree_test_result_out_o,
    .tree_test_result_oe_o, .external_reset_o);
  drpor_board i_brd (.pull_low_i(pull), .strap_high_i(strap), .dev_oe_i(main_rail_reset_n_oe_o),
    .pin_level_o(main_rail_reset_n_i), .strap_o(diode_cathode_pin_i));
  always #4 clock_i = ~clock_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Half the draws are all ones, the only pattern that drives the tree result low.
  always @(posedge clock_i)
  begin
    seed <= xs(seed);
    tree_inputs_i <= seed[8] ? 8'hFF : seed[7:0];
  end
  // Each change of a reset output must match the oldest noted level.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 1500)
    begin
      fails++;
      conclude();
    end
    cur = {main_rail_reset_n_i, standby_rail_reset_n_o};
    for (int k = 0; k < 2; k++)
      if (reset_n_i && cur[k] !== last[k])
        chk(cur[k], q[k].size() ? q[k].pop_front() : last[k]);
    if (reset_n_i)
      last = cur;
    if (tree_test_mode_o && pm)
      chk(tree_test_result_out_o, ~&tp);
    if (reset_n_i)
      chk(tree_test_result_oe_o, tree_test_mode_o);
    pm = tree_test_mode_o;
    tp = tree_inputs_i;
  end
  // Walk the step table, noting each expected edge before applying the step.
  initial
  begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'h1;
    foreach (tbl[i])
    begin
      if (tbl[i][11] != pv[11])
        q[0].push_back(tbl[i][11]);
      if (tbl[i][10] != pv[10])
        q[1].push_back(tbl[i][10]);
      pv = tbl[i];
      standby_supply_ok_i <= tbl[i][15];
      main_supply_ok_i <= tbl[i][14];
      pull <= tbl[i][13];
      strap <= tbl[i][12];
      repeat (tbl[i][7:0]) @(posedge clock_i);
      chk(external_reset_o, tbl[i][13]);
      chk(standby_rail_reset_n_o, tbl[i][11]);
      chk(main_rail_reset_n_i, tbl[i][10]);
      if (tbl[i][15])
        chk(tree_test_mode_o, tbl[i][12]);
    end
    conclude();
  end
endmodule // tb_top
bind drpor_sequencer drpor_chk_sva #(.SLOW_DIV(SLOW_DIV), .HOLD_TICKS(HOLD_TICKS)) i_chk (.clock_i, .reset_n_i,
  .standby_supply_ok_i, .main_supply_ok_i, .main_rail_reset_n_i, .main_rail_reset_n_o, .main_rail_reset_n_oe_o,
  .standby_rail_reset_n_o, .tree_inputs_i, .tree_test_mode_o, .tree_test_result_out_o, .external_reset_o);
